// >>> core/emb_bus.sv
// Purpose: external memory bus, clock output and reset sequence
// Assumes: pins synchronous to ref_clk_i; one state time is three clocks
// Notes: all pin outputs except clock output and pc_o lag the state registers by one clock
// How it works
// - clock output is oscillator over three, high one clock in three
// - reset release restarts clock output, then ten state times of setup
// - setup clears status word, loads config from 2018H, branches 2080H
// - width enable set: width pin low gives an 8-bit cycle
// - width enable clear: every cycle is 8 bits
// - rising edge of nmi input vectors execution to 0000H
// - fetch indicator high for the whole external instruction read
// - access select low sends 2000H to 3FFFH off chip
// - latch or address valid output, chosen by config, only for external
// - address valid form stays low through the access as chip select
// - read strobe only on external reads
// - write form low on every write; low byte form on even bytes only
// - high byte enable low selects high bank; lsb low selects low bank
// - high byte write form low only when writing an odd location
// - ready low before clock falls waits for clock rise with ready high
// - ready ignored when no external access runs
// - config field limits the number of wait states
// - top sixteen register file bytes survive reset
// - two 8-bit ports double as the address/data bus
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
module emb_bus (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic clock_output_o,
  input wire logic bus_width_select_i,
  input wire logic external_access_select_i,
  input wire logic nmi_i,
  input wire logic ready_i,
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic [15:0] ad_oe_o,
  output logic addr_strobe_o,
  output logic rd_b_o,
  output logic write_low_byte_strobe_b_o,
  output logic high_byte_enable_b_o,
  output logic fetch_indicator_o,
  output logic [15:0] pc_o
);
  import emb_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  logic wait_reg;
  logic [31:0] rdd_reg;
  logic [1:0] ph_reg;
  logic clk_reg;
  emb_state_type st_reg;
  logic [7:0] ccr_reg;
  logic [7:0] psw_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [15:0] port_reg;
  logic [15:0] pc_reg;
  logic [31:0] keep_reg [0:3];
  logic pend_reg;
  logic [15:0] op_addr_reg;
  logic [15:0] op_wd_reg;
  logic op_write_reg;
  logic op_word_reg;
  logic op_fetch_reg;
  logic op_init_reg;
  logic wide_reg;
  logic hi_reg;
  logic rdy_reg;
  logic [2:0] wcnt_reg;
  logic [3:0] icnt_reg;
  logic isent_reg;
  logic idone_reg;
  logic nmi_d_reg;
  logic nmi_pend_reg;
  logic nmi_flag_reg;
  logic ale_reg;
  logic rd_reg;
  logic wr_reg;
  logic bhe_reg;
  logic fetch_reg;
  logic [15:0] ad_reg;
  logic [15:0] oe_reg;

  // register bus: one wait cycle, then the answer
  wire wr_acc = avs_write_i & ~wait_reg;
  wire wait_next = ~((avs_read_i | avs_write_i) & wait_reg);
  wire keep_hit = (avs_address_i[7:4] == OFF_KEEP[7:4]);
  wire [1:0] keep_idx = avs_address_i[3:2];

  wire st_end = (ph_reg == 2'd2);
  wire [1:0] ph_next = st_end ? 2'd0 : ph_reg + 2'd1;
  wire st_idle = (st_reg == ST_IDLE);
  wire busy = pend_reg | ~st_idle;

  wire [15:0] cur_addr = op_addr_reg + {15'h0000, hi_reg};
  wire a0 = cur_addr[0];
  wire ea_win = (op_addr_reg >= EA_LO) && (op_addr_reg <= EA_HI);
  wire is_ext = (ea_win & ~external_access_select_i) | (op_addr_reg >= EXT_FROM) |
                (op_addr_reg == NMI_VECTOR);
  // 16-bit when enabled and pin high
  wire wide_next = ccr_reg[CCR_BW_EN] & bus_width_select_i;
  wire second = ~wide_reg & op_word_reg & ~hi_reg;

  wire [1:0] wlim_f = ccr_reg[CCR_WLIM+1:CCR_WLIM];
  wire [2:0] wlim = (wlim_f == 2'b11) ? 3'(WAIT_CAP) : {1'b0, wlim_f} + 3'd1;

  wire in_acc = (st_reg == ST_ADDR) | (st_reg == ST_DATA) | (st_reg == ST_WAIT);
  wire rw_ph = (st_reg == ST_DATA) | (st_reg == ST_WAIT);
  wire lo_w = wide_reg ? (op_word_reg | ~a0) : ~a0;
  wire hi_w = wide_reg ? (op_word_reg | a0) : a0;

  wire [15:0] rd_val = wide_reg ? (op_word_reg ? ad_i : (a0 ? {8'h00, ad_i[15:8]} : {8'h00, ad_i[7:0]})) :
                       (hi_reg ? {ad_i[7:0], rdata_reg[7:0]} : {8'h00, ad_i[7:0]});
  wire leave_data = (st_reg == ST_DATA) & st_end & rdy_reg;
  wire leave_wait = (st_reg == ST_WAIT) & st_end & (rdy_reg | (wcnt_reg + 3'd1 >= wlim));
  wire cap = (leave_data | leave_wait) & ~op_write_reg;
  wire int_done = st_idle & pend_reg & st_end & ~is_ext;
  wire done = int_done | ((st_reg == ST_DONE) & st_end & ~second);

  wire nmi_rise = nmi_i & ~nmi_d_reg;
  wire init_take = ~idone_reg & ~isent_reg & st_end & ~busy;
  wire nmi_take = idone_reg & nmi_pend_reg & ~busy;
  wire cmd_take = idone_reg & ~nmi_pend_reg & ~busy & wr_acc & hit(avs_address_i, OFF_CMD);
  wire init_fin = ~idone_reg & isent_reg & st_end & ~busy & (icnt_reg >= 4'(INIT_STATES - 1));

  wire [31:0] stat_w = {16'h0000, psw_reg, 5'h00, nmi_flag_reg, idone_reg, busy};
  wire [31:0] rd_mux = keep_hit ? keep_reg[keep_idx] :
                       hit(avs_address_i, OFF_CCR) ? {24'h000000, ccr_reg} :
                       hit(avs_address_i, OFF_ADDR) ? {16'h0000, addr_reg} :
                       hit(avs_address_i, OFF_WDATA) ? {16'h0000, wdata_reg} :
                       hit(avs_address_i, OFF_RDATA) ? {16'h0000, rdata_reg} :
                       hit(avs_address_i, OFF_STATUS) ? stat_w :
                       hit(avs_address_i, OFF_PC) ? {16'h0000, pc_reg} :
                       hit(avs_address_i, OFF_PORT) ? {ad_i, port_reg} : 32'h00000000;

  wire ale_v = ccr_reg[CCR_ADV] ? ~in_acc : ((st_reg == ST_ADDR) & (ph_reg != 2'd2));
  wire rd_v = ~(rw_ph & ~op_write_reg);
  wire wr_v = ~(rw_ph & op_write_reg & (ccr_reg[CCR_WRL] ? lo_w : 1'b1));
  wire bhe_v = ccr_reg[CCR_WRH] ? ~(rw_ph & op_write_reg & hi_w) : ~(in_acc & wide_reg & hi_w);
  wire fetch_v = (in_acc | (st_reg == ST_DONE)) & op_fetch_reg & ~op_write_reg;
  wire [7:0] wb = hi_reg ? op_wd_reg[15:8] : op_wd_reg[7:0];
  wire [15:0] wdl = wide_reg ? ((~op_word_reg & a0) ? {wb, wb} : op_wd_reg) : {8'h00, wb};
  // ports carry the bus, open drain otherwise
  wire [15:0] ad_v = (st_reg == ST_ADDR) ? cur_addr : (rw_ph & op_write_reg) ? wdl : port_reg;
  wire [15:0] oe_v = (st_reg == ST_ADDR) | (rw_ph & op_write_reg) ? 16'hFFFF :
                     rw_ph ? 16'h0000 : ~port_reg;

  emb_state_type st_next;
  always_comb begin
    st_next = st_reg;
    if (st_end) begin
      unique case (st_reg)
        ST_IDLE: st_next = (pend_reg & is_ext) ? ST_ADDR : ST_IDLE;
        ST_ADDR: st_next = ST_DATA;
        // ready low before the fall waits
        ST_DATA: st_next = rdy_reg ? ST_DONE : ST_WAIT;
        ST_WAIT: st_next = leave_wait ? ST_DONE : ST_WAIT;
        ST_DONE: st_next = second ? ST_ADDR : ST_IDLE;
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_reg <= 2'd0;
      clk_reg <= 1'b0;
      st_reg <= ST_IDLE;
    end else begin
      ph_reg <= ph_next;
      clk_reg <= (ph_next == 2'd0);
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg <= 1'b1;
      rdd_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      rdd_reg <= (avs_read_i & wait_reg) ? rd_mux : rdd_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_acc & keep_hit) begin
      keep_reg[keep_idx] <= avs_writedata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ccr_reg <= CCR_RST;
      psw_reg <= PSW_RST;
      addr_reg <= 16'h0000;
      wdata_reg <= 16'h0000;
      port_reg <= PORT_RST;
      nmi_flag_reg <= 1'b0;
    end else begin
      // config byte loaded by setup read
      if (done & op_init_reg) ccr_reg <= rdata_reg[7:0];
      else if (wr_acc & hit(avs_address_i, OFF_CCR) & avs_byteenable_i[0]) ccr_reg <= avs_writedata_i[7:0];
      if (~idone_reg) psw_reg <= PSW_RST;
      else if (wr_acc & hit(avs_address_i, OFF_STATUS) & avs_byteenable_i[1]) psw_reg <= avs_writedata_i[15:8];
      if (wr_acc & hit(avs_address_i, OFF_ADDR)) addr_reg <= merge(addr_reg, avs_writedata_i, avs_byteenable_i);
      if (wr_acc & hit(avs_address_i, OFF_WDATA)) wdata_reg <= merge(wdata_reg, avs_writedata_i, avs_byteenable_i);
      if (wr_acc & hit(avs_address_i, OFF_PORT)) port_reg <= merge(port_reg, avs_writedata_i, avs_byteenable_i);
      // set wins over the write-one clear
      nmi_flag_reg <= nmi_take | (nmi_flag_reg &
        ~(wr_acc & hit(avs_address_i, OFF_STATUS) & avs_byteenable_i[0] & avs_writedata_i[STAT_NMI]));
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg <= 1'b0;
      op_addr_reg <= 16'h0000;
      op_wd_reg <= 16'h0000;
      op_write_reg <= 1'b0;
      op_word_reg <= 1'b0;
      op_fetch_reg <= 1'b0;
      op_init_reg <= 1'b0;
    end else if (init_take | nmi_take | cmd_take) begin
      pend_reg <= 1'b1;
      op_addr_reg <= init_take ? CCR_FETCH_ADDR : nmi_take ? NMI_VECTOR : addr_reg;
      op_wd_reg <= wdata_reg;
      op_write_reg <= cmd_take & avs_writedata_i[CMD_WRITE];
      op_word_reg <= cmd_take & avs_writedata_i[CMD_WORD];
      op_fetch_reg <= nmi_take | (cmd_take & avs_writedata_i[CMD_FETCH]);
      op_init_reg <= init_take;
    end else if (st_idle & st_end) begin
      pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wide_reg <= 1'b0;
      hi_reg <= 1'b0;
      rdy_reg <= 1'b1;
      wcnt_reg <= 3'd0;
      rdata_reg <= 16'h0000;
    end else begin
      if (st_idle & st_end) wide_reg <= wide_next;
      if (st_idle) hi_reg <= 1'b0;
      else if ((st_reg == ST_DONE) & st_end & second) hi_reg <= 1'b1;
      // ready looked at only in data and wait
      if (rw_ph & (ph_reg == 2'd0)) rdy_reg <= ready_i;
      if ((st_reg == ST_WAIT) & st_end) wcnt_reg <= wcnt_reg + 3'd1;
      else if (st_reg == ST_ADDR) wcnt_reg <= 3'd0;
      if (cap) rdata_reg <= rd_val;
      else if (int_done) rdata_reg <= 16'h0000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      icnt_reg <= 4'd0;
      isent_reg <= 1'b0;
      idone_reg <= 1'b0;
      pc_reg <= 16'h0000;
      nmi_d_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end else begin
      if (~idone_reg & st_end & (icnt_reg < 4'(INIT_STATES - 1))) icnt_reg <= icnt_reg + 4'd1;
      if (init_take) isent_reg <= 1'b1;
      if (init_fin) idone_reg <= 1'b1;
      nmi_d_reg <= nmi_i;
      // vector to 0000H on rising edge
      nmi_pend_reg <= (nmi_rise & idone_reg) | (nmi_pend_reg & ~nmi_take);
      if (init_fin) pc_reg <= RESET_PC;
      else if (nmi_take) pc_reg <= NMI_VECTOR;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ale_reg <= 1'b0;
      rd_reg <= 1'b1;
      wr_reg <= 1'b1;
      bhe_reg <= 1'b1;
      fetch_reg <= 1'b0;
      ad_reg <= 16'h0000;
      oe_reg <= 16'h0000;
    end else begin
      ale_reg <= ale_v;
      rd_reg <= rd_v;
      wr_reg <= wr_v;
      bhe_reg <= bhe_v;
      fetch_reg <= fetch_v;
      ad_reg <= ad_v;
      oe_reg <= oe_v;
    end
  end

  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o = rdd_reg;
  assign clock_output_o = clk_reg;
  assign addr_strobe_o = ale_reg;
  assign rd_b_o = rd_reg;
  assign write_low_byte_strobe_b_o = wr_reg;
  assign high_byte_enable_b_o = bhe_reg;
  assign fetch_indicator_o = fetch_reg;
  assign ad_o = ad_reg;
  assign ad_oe_o = oe_reg;
  assign pc_o = pc_reg;

  logic [7:0] up_reg;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) up_reg <= 8'd0;
    else if (~idone_reg && up_reg != 8'hFF) up_reg <= up_reg + 8'd1;
  end

  property p_clk;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      clock_output_o |=> !clock_output_o ##1 !clock_output_o ##1 clock_output_o;
  endproperty
  a_clk: assert property (p_clk) else $error("clock output duty wrong");
  property p_init_len;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(idone_reg) |-> (up_reg >= 8'd29);
  endproperty
  a_init_len: assert property (p_init_len) else $error("setup shorter than ten states");
  property p_init_pc;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(idone_reg) |-> (pc_reg == RESET_PC) && (psw_reg == PSW_RST);
  endproperty
  a_init_pc: assert property (p_init_pc) else $error("setup branch or status wrong");
  property p_narrow;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (st_idle && st_end && !ccr_reg[CCR_BW_EN]) |=> !wide_reg;
  endproperty
  a_narrow: assert property (p_narrow) else $error("wide cycle with width disabled");
  property p_width;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (st_idle && st_end && ccr_reg[CCR_BW_EN]) |=> wide_reg == $past(bus_width_select_i);
  endproperty
  a_width: assert property (p_width) else $error("width pin not followed");
  property p_nmi;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      nmi_take |=> (pc_reg == NMI_VECTOR) && pend_reg && (op_addr_reg == NMI_VECTOR);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi vector not taken");
  property p_rd;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      !rd_b_o |-> $past(rw_ph) && !op_write_reg;
  endproperty
  a_rd: assert property (p_rd) else $error("read strobe outside external read");
  property p_wait;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      ((st_reg == ST_DATA) && st_end && !rdy_reg) |=> (st_reg == ST_WAIT) [*3];
  endproperty
  a_wait: assert property (p_wait) else $error("ready low gave no wait");
  property p_wlim;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (st_reg == ST_WAIT) |-> wcnt_reg < wlim;
  endproperty
  a_wlim: assert property (p_wlim) else $error("wait limit exceeded");
  property p_ale;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
      (addr_strobe_o && !$past(ccr_reg[CCR_ADV])) |-> $past(st_reg) == ST_ADDR;
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe outside access");
  c_wait: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) leave_wait);
  c_two: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) (st_reg == ST_DONE) && st_end && second);
  c_nmi: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) nmi_take);
endmodule

// >>> core/emb_pkg.sv
// Purpose: shared constants and types of the external memory bus block
// Assumes: one oscillator clock at 20 MHz, registers reached over Avalon-MM
// Notes: byte offsets on the register bus, one aligned word each
package emb_pkg;
  localparam int OSC_HZ = 20_000_000;
  localparam int CLK_NS = 1_000_000_000 / OSC_HZ;
  localparam int STATE_OSC = 3;
  localparam int INIT_STATES = 10;
  localparam int RESET_MIN_STATES = 2;
  localparam int READY_MAX_NS = 1000;
  localparam int WAIT_CAP = READY_MAX_NS / (CLK_NS * STATE_OSC);
  localparam logic [15:0] CCR_FETCH_ADDR = 16'h2018;
  localparam logic [15:0] RESET_PC = 16'h2080;
  localparam logic [15:0] NMI_VECTOR = 16'h0000;
  localparam logic [15:0] EA_LO = 16'h2000;
  localparam logic [15:0] EA_HI = 16'h3FFF;
  localparam logic [15:0] EXT_FROM = 16'h4000;
  localparam int CCR_BW_EN = 1;
  localparam int CCR_ADV = 2;
  localparam int CCR_WRL = 3;
  localparam int CCR_WRH = 4;
  localparam int CCR_WLIM = 5;
  localparam logic [7:0] OFF_CCR = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;
  localparam logic [7:0] OFF_PORT = 8'h1C;
  localparam logic [7:0] OFF_KEEP = 8'h20;
  localparam int CMD_WRITE = 0;
  localparam int CMD_WORD = 1;
  localparam int CMD_FETCH = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_INIT = 1;
  localparam int STAT_NMI = 2;
  localparam int STAT_PSW = 8;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [15:0] PORT_RST = 16'hFFFF;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_WAIT = 5'h08,
    ST_DONE = 5'h10
  } emb_state_type;
endpackage

// >>> testbench/emb_bus_bench.sv
// Purpose: self-checking bench for the external memory bus block
// Assumes: memory model on the far side, registers over Avalon-MM
// Notes: bus activity counted at the falling clock edge
`timescale 1ns/1ns
module emb_bus_bench;
  import emb_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic bw = 1'b1;
  logic eas = 1'b0;
  logic nmi = 1'b0;
  logic vmode = 1'b0;
  logic hold = 1'b0;
  logic [2:0] stall = 3'h0;
  logic [31:0] rdat;
  logic rdb_q = 1'b1;
  logic wlb_q = 1'b1;
  wire [31:0] rdo;
  wire wrq, co, rdy, as, rdb, wlb, hbb, fi;
  wire [15:0] adi, ado, adoe, pc;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt [8];
  emb_bus dut (.ref_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdo), .avs_waitrequest_o(wrq),
    .clock_output_o(co), .bus_width_select_i(bw), .external_access_select_i(eas), .nmi_i(nmi),
    .ready_i(rdy), .ad_i(adi), .ad_o(ado), .ad_oe_o(adoe), .addr_strobe_o(as), .rd_b_o(rdb),
    .write_low_byte_strobe_b_o(wlb), .high_byte_enable_b_o(hbb), .fetch_indicator_o(fi), .pc_o(pc));
  emb_mem_model mem_u (.ref_clk_i(clk), .clock_output_i(co), .addr_strobe_i(as), .valid_mode_i(vmode),
    .rd_b_i(rdb), .wr_b_i(wlb), .hb_b_i(hbb), .ad_o_i(ado), .ad_oe_i(adoe), .stall_i(stall),
    .hold_low_i(hold), .ad_i_o(adi), .ready_o(rdy));
  initial begin
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    cnt[0] += int'(rdb_q && !rdb);
    cnt[1] += int'(wlb_q && !wlb);
    cnt[2] += int'(!rdb);
    cnt[3] += int'(!hbb);
    cnt[4] += int'(as ^ vmode);
    cnt[5] += int'(fi);
    cnt[6] += int'(!rdb && !fi);
    cnt[7] += int'(vmode && as && !rdb);
    rdb_q = rdb;
    wlb_q = wlb;
  end
  function automatic logic [7:0] e8(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wrq !== 1'b0);
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic run(input logic [15:0] a, input logic [2:0] c);
    av(1'b1, OFF_ADDR, {16'h0, a});
    foreach (cnt[i]) cnt[i] = 0;
    av(1'b1, OFF_CMD, {29'h0, c});
    rdat = 32'h1;
    for (int k = 0; k < 40 && rdat[STAT_BUSY]; k++) av(1'b0, OFF_STATUS, 32'h0);
    av(1'b0, OFF_RDATA, 32'h0);
  endtask
  task automatic t_reset();
    logic [9:0] pat;
    int t0;
    // reset low from power-up for two state times
    repeat (STATE_OSC * RESET_MIN_STATES) @(posedge clk);
    rst_b <= 1'b1;
    t0 = cyc;
    pat = 10'h0;
    repeat (10) begin
      @(posedge clk);
      pat = {pat[8:0], co};
    end
    chk("clock output", {22'h0, pat}, 32'h049);
    rdat = 32'h0;
    for (int k = 0; k < 40 && !rdat[STAT_INIT]; k++) av(1'b0, OFF_STATUS, 32'h0);
    chk("setup length", {31'h0, cyc - t0 >= 3 * INIT_STATES}, 1);
    chk("status word", {24'h0, rdat[15:8]}, 0);
    chk("branch pin", {16'h0, pc}, {16'h0, RESET_PC});
    av(1'b0, OFF_PC, 32'h0);
    chk("branch reg", rdat, {16'h0, RESET_PC});
    av(1'b0, OFF_CCR, 32'h0);
    chk("config load", rdat, 32'h2);
    av(1'b0, OFF_PORT, 32'h0);
    chk("port idle", rdat, 32'hFFFFFFFF);
    av(1'b0, 8'h30, 32'h0);
    chk("unmapped", rdat, 0);
  endtask
  task automatic t_width();
    for (int c = 0; c < 3; c++) begin
      av(1'b1, OFF_CCR, (c == 2) ? 32'h0 : 32'h2);
      bw <= (c != 1);
      run(16'h4020, 3'h2);
      chk("word data", rdat, {16'h0, e8(16'h4021), e8(16'h4020)});
      chk("byte cycles", cnt[0], (c == 0) ? 1 : 2);
      chk("bus address", {16'h0, mem_u.addr_reg}, (c == 0) ? 32'h4020 : 32'h4021);
    end
  endtask
  task automatic t_fetch();
    av(1'b1, OFF_CCR, 32'h2);
    run(16'h4031, 3'h4);
    chk("fetch gap", cnt[6], 0);
    chk("fetch seen", {31'h0, cnt[5] > 0}, 1);
    run(16'h4031, 3'h0);
    chk("fetch on data", cnt[5], 0);
    chk("byte data", rdat, {24'h0, e8(16'h4031)});
    av(1'b1, OFF_WDATA, 32'h00C3);
    run(16'h4032, 3'h1);
    chk("read on write", cnt[0], 0);
    chk("written byte", {24'h0, mem_u.mem[16'h4032]}, 32'hC3);
  endtask
  task automatic t_access();
    for (int s = 0; s < 2; s++) begin
      eas <= s[0];
      run(16'h2100, 3'h0);
      chk("off chip reads", cnt[0], 1 - s);
      chk("strobe clocks", {31'h0, cnt[4] > 0}, 1 - s);
      chk("range data", rdat, (s == 0) ? {24'h0, e8(16'h2100)} : 32'h0);
    end
    eas <= 1'b0;
  endtask
  task automatic wcase(input logic [7:0] cfg, input logic [15:0] a, input int nw, input int hb);
    av(1'b1, OFF_CCR, {24'h0, cfg});
    run(a, 3'h1);
    chk("write strobes", cnt[1], nw);
    chk("high byte clocks", {31'h0, cnt[3] > 0}, hb);
  endtask
  task automatic t_write();
    av(1'b1, OFF_WDATA, 32'h00C3);
    wcase(8'h02, 16'h4040, 1, 0);
    wcase(8'h02, 16'h4041, 1, 1);
    chk("odd byte", {24'h0, mem_u.mem[16'h4041]}, 32'hC3);
    wcase(8'h0A, 16'h4041, 0, 1);
    wcase(8'h0A, 16'h4040, 1, 0);
    wcase(8'h12, 16'h4041, 1, 1);
    wcase(8'h12, 16'h4040, 1, 0);
  endtask
  task automatic t_valid();
    av(1'b1, OFF_CCR, 32'h6);
    vmode <= 1'b1;
    run(16'h4050, 3'h0);
    chk("select gaps", cnt[7], 0);
    chk("select clocks", {31'h0, cnt[4] > 2}, 1);
    chk("select data", rdat, {24'h0, e8(16'h4050)});
    chk("select idle", {31'h0, as}, 1);
    av(1'b1, OFF_CCR, 32'h2);
    vmode <= 1'b0;
  endtask
  task automatic t_ready();
    stall <= 3'h6;
    av(1'b1, OFF_CCR, 32'h02);
    run(16'h4060, 3'h0);
    chk("read clocks cap 1", cnt[2], 6);
    av(1'b1, OFF_CCR, 32'h22);
    run(16'h4060, 3'h0);
    chk("read clocks cap 2", cnt[2], 9);
    stall <= 3'h2;
    av(1'b1, OFF_CCR, 32'h62);
    run(16'h4061, 3'h0);
    chk("stretched read", {31'h0, cnt[2] > 3 && cnt[2] % 3 == 0}, 1);
    chk("stretched data", rdat, {24'h0, e8(16'h4061)});
    stall <= 3'h0;
    run(16'h4062, 3'h0);
    chk("no wait read", cnt[2], 3);
    hold <= 1'b1;
    eas <= 1'b1;
    run(16'h2100, 3'h0);
    av(1'b0, OFF_STATUS, 32'h0);
    chk("internal idle", {31'h0, rdat[STAT_BUSY]}, 0);
    hold <= 1'b0;
    eas <= 1'b0;
  endtask
  task automatic t_nmi();
    nmi <= 1'b1;
    rdat = 32'h0;
    for (int k = 0; k < 20 && !rdat[STAT_NMI]; k++) av(1'b0, OFF_STATUS, 32'h0);
    chk("vector pin", {16'h0, pc}, {16'h0, NMI_VECTOR});
    nmi <= 1'b0;
    av(1'b1, OFF_STATUS, 32'h4);
    av(1'b0, OFF_STATUS, 32'h0);
    chk("vector flag", {31'h0, rdat[STAT_NMI]}, 0);
  endtask
  task automatic t_keep();
    av(1'b1, OFF_KEEP, 32'hC35A0F96);
    // second reset, two state times low
    rst_b <= 1'b0;
    repeat (STATE_OSC * RESET_MIN_STATES) @(posedge clk);
    rst_b <= 1'b1;
    rdat = 32'h0;
    for (int k = 0; k < 40 && !rdat[STAT_INIT]; k++) av(1'b0, OFF_STATUS, 32'h0);
    chk("setup again", {31'h0, rdat[STAT_INIT]}, 1);
    chk("branch again", {16'h0, pc}, {16'h0, RESET_PC});
    av(1'b0, OFF_CCR, 32'h0);
    chk("config again", rdat, 32'h2);
    av(1'b0, OFF_KEEP, 32'h0);
    chk("kept word", rdat, 32'hC35A0F96);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 65536; i++) mem_u.mem[i] = e8(16'(i));
    mem_u.mem[CCR_FETCH_ADDR] = 8'h02;
    t_reset();
    t_width();
    t_fetch();
    t_access();
    t_write();
    t_valid();
    t_ready();
    t_nmi();
    t_keep();
    finish_test();
  end
endmodule

// >>> testbench/emb_mem_model.sv
// Purpose: external memory on the multiplexed address/data bus
// Assumes: open drain bus with pullups; address taken in the address phase
// Notes: ready held low for stall_i state times, six at most, from each address phase
`timescale 1ns/1ns
module emb_mem_model (
  input wire logic ref_clk_i,
  input wire logic clock_output_i,
  input wire logic addr_strobe_i,
  input wire logic valid_mode_i,
  input wire logic rd_b_i,
  input wire logic wr_b_i,
  input wire logic hb_b_i,
  input wire logic [15:0] ad_o_i,
  input wire logic [15:0] ad_oe_i,
  input wire logic [2:0] stall_i,
  input wire logic hold_low_i,
  output logic [15:0] ad_i_o,
  output logic ready_o
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic hb_reg;
  logic [3:0] cnt_reg = 4'hF;
  logic co_reg = 1'b0;
  logic wr_q_reg = 1'b1;
  wire addr_phase = (addr_strobe_i ^ valid_mode_i) && rd_b_i && wr_b_i;
  wire [15:0] rd_data = {mem[addr_reg | 16'h0001], mem[addr_reg]};
  wire [2:0] stall = (stall_i > 3'h6) ? 3'h6 : stall_i;
  // released lines float high through the pullups
  assign ad_i_o = (ad_oe_i & ad_o_i) | (~ad_oe_i & (rd_b_i ? 16'hFFFF : rd_data));
  // ready low six states at most, under 1 us, unless hold_low_i holds it low
  assign ready_o = ~hold_low_i && (cnt_reg >= {1'b0, stall});
  always @(posedge ref_clk_i) begin
    co_reg <= clock_output_i;
    wr_q_reg <= wr_b_i;
    if (addr_phase) begin
      addr_reg <= ad_o_i;
      cnt_reg <= 4'h0;
    end else if (clock_output_i && !co_reg && cnt_reg != 4'hF) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    if (!wr_b_i) begin
      wdata_reg <= ad_i_o;
      hb_reg <= hb_b_i;
    end
    if (wr_b_i && !wr_q_reg) begin
      mem[addr_reg] <= wdata_reg[7:0];
      if (!hb_reg && !addr_reg[0]) begin
        mem[addr_reg | 16'h0001] <= wdata_reg[15:8];
      end
    end
  end
endmodule
